/* verilog/ifc_classifier.sv */
// ipv4 frame filter classifier top: entry_list store, match, action
`timescale 1ns/1ps
`default_nettype none
// How it works
// - permit hit: frame forwarded and its source address learned
// - deny hit: frame dropped, never forwarded
// - shutdown action exists; frame dropped, reported, no port shutdown
// - protocol_dont_care set: protocol field not compared
// - otherwise frame protocol must equal the entry protocol
// - source selector any: source address ignored
// - user source: compare source address with stored 32-bit value
// - user source: per-entry source_address_mask limits compared bits
// - destination selector any: destination address ignored
// - user destination: compare with stored 32-bit value
// - user destination: destination_address_mask limits compared bits
// - source port any: ignored
// - source port single: must equal configured 16-bit value
// - source port range: must lie within configured bounds
// - destination port any: ignored
// - destination port single: must equal configured value
// - destination port range: must lie within configured bounds
// - urg term: set needs flag, unset forbids it, dont care ignores
// - ack term: set needs flag, unset forbids it, dont care ignores
// - psh term: set needs flag, unset forbids it, dont care ignores
// - rst term: set needs flag, unset forbids it, dont care ignores
// - entry not installable for lack of range units is flagged conflict
module ifc_classifier
   import ifc_pkg::*;
#(
   parameter int N = IFC_ENTRIES,
   parameter int RANGE_UNITS = IFC_RANGE_UNITS,
   parameter int IW = (N > 1) ? $clog2(N) : 1
)
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   // entry_list configuration
   input wire logic cfg_wr_in,
   input wire logic [IW-1:0] cfg_idx_in,
   input wire ifc_entry_s cfg_entry_in,
   input wire logic cfg_clear_in,
   input wire logic [IW-1:0] cfg_rd_idx_in,
   output ifc_entry_s cfg_rd_entry_out,
   output logic cfg_rd_conflict_out,
   output logic cfg_rd_installed_out,
   output logic [N-1:0] conflict_out,
   output logic [N-1:0] installed_out,
   input wire logic miss_drop_in,
   // frame stream
   input wire logic frm_valid_in,
   input wire ifc_frame_s frm_in,
   output logic res_valid_out,
   output logic res_forward_out,
   output logic res_learn_out,
   output logic res_drop_out,
   output logic res_shutdown_out,
   output logic res_hit_out,
   output logic [IW-1:0] res_idx_out,
   // statistics
   output logic [IFC_CNT_W-1:0] fwd_count_out,
   output logic [IFC_CNT_W-1:0] drop_count_out,
   output logic [IFC_CNT_W-1:0] shut_count_out
);

   // ----------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------
   if (N < 1 || (1 << IW) < N) begin : g_bad_n
      $error("entry count does not fit the index width");
   end
   if (RANGE_UNITS < 0 || RANGE_UNITS > 2 * N) begin : g_bad_r
      $error("range unit count out of reach");
   end

   localparam logic [IW-1:0] LAST_IDX = IW'(N - 1);

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   ifc_entry_s table_reg [N];
   logic [N-1:0] installed_reg;
   logic [N-1:0] conflict_reg;
   logic [N-1:0] hit_vec;
   logic [N-1:0] units_vec_sp;
   logic [N-1:0] units_vec_dp;

   ifc_entry_s rd_entry_reg;
   logic rd_conflict_reg;
   logic rd_installed_reg;

   logic res_valid_reg;
   logic res_forward_reg;
   logic res_learn_reg;
   logic res_drop_reg;
   logic res_shutdown_reg;
   logic res_hit_reg;
   logic [IW-1:0] res_idx_reg;

   logic res_forward_next;
   logic res_learn_next;
   logic res_drop_next;
   logic res_shutdown_next;

   logic [IFC_CNT_W-1:0] fwd_count_reg;
   logic [IFC_CNT_W-1:0] drop_count_reg;
   logic [IFC_CNT_W-1:0] shut_count_reg;

   // ----------------------------------------------------------
   // per-entry match and range unit usage
   // ----------------------------------------------------------
   for (genvar g = 0; g < N; g++) begin : g_entry
      logic match;
      ifc_entry_match u_match (
         .entry_in(table_reg[g]),
         .frame_in(frm_in),
         .hit_out(match)
      );
      // only installed entries take part
      assign hit_vec[g] = installed_reg[g] && match;
      assign units_vec_sp[g] = installed_reg[g] &&
         (table_reg[g].sp_sel == IFC_PSEL_RANGE);
      assign units_vec_dp[g] = installed_reg[g] &&
         (table_reg[g].dp_sel == IFC_PSEL_RANGE);
   end

   // ----------------------------------------------------------
   // first hit
   // ----------------------------------------------------------
   wire logic any_hit;
   wire logic [IW-1:0] hit_idx;

   ifc_first_hit #(
      .N(N),
      .IW(IW)
   ) u_first (
      .hits_in(hit_vec),
      .any_out(any_hit),
      .idx_out(hit_idx)
   );

   wire ifc_action_e hit_action;
   assign hit_action = table_reg[hit_idx].action;

   // ----------------------------------------------------------
   // install check
   // ----------------------------------------------------------
   // each range term needs one hardware range comparator
   wire logic idx_ok;
   wire logic wr_go;
   wire logic wr_sp_range;
   wire logic wr_dp_range;
   wire logic wr_conflict;
   int used_other;
   int new_units;

   assign idx_ok = (cfg_idx_in <= LAST_IDX);
   assign wr_go = cfg_wr_in && idx_ok && !cfg_clear_in;
   assign wr_sp_range = cfg_entry_in.sp_sel == IFC_PSEL_RANGE;
   assign wr_dp_range = cfg_entry_in.dp_sel == IFC_PSEL_RANGE;

   always_comb begin
      used_other = 0;
      for (int i = 0; i < N; i++) begin
         if (IW'(i) != cfg_idx_in) begin
            used_other = used_other + int'(units_vec_sp[i]) +
                         int'(units_vec_dp[i]);
         end
      end
      new_units = int'(wr_sp_range) + int'(wr_dp_range);
   end

   assign wr_conflict = cfg_entry_in.valid &&
      (used_other + new_units > RANGE_UNITS);

   // ----------------------------------------------------------
   // entry_list store
   // ----------------------------------------------------------
   // a frame in the write cycle still sees the old entry
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < N; i++) begin
            table_reg[i] <= IFC_ENTRY_RST;
         end
      end else if (cfg_clear_in) begin
         for (int i = 0; i < N; i++) begin
            table_reg[i] <= IFC_ENTRY_RST;
         end
      end else if (wr_go) begin
         table_reg[cfg_idx_in] <= cfg_entry_in;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         installed_reg <= '0;
         conflict_reg <= '0;
      end else if (cfg_clear_in) begin
         installed_reg <= '0;
         conflict_reg <= '0;
      end else if (wr_go) begin
         installed_reg[cfg_idx_in] <= cfg_entry_in.valid && !wr_conflict;
         conflict_reg[cfg_idx_in] <= wr_conflict;
      end
   end

   // ----------------------------------------------------------
   // read back
   // ----------------------------------------------------------
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_entry_reg <= IFC_ENTRY_RST;
         rd_conflict_reg <= 1'b0;
         rd_installed_reg <= 1'b0;
      end else begin
         rd_entry_reg <= table_reg[cfg_rd_idx_in];
         rd_conflict_reg <= conflict_reg[cfg_rd_idx_in];
         rd_installed_reg <= installed_reg[cfg_rd_idx_in];
      end
   end

   // ----------------------------------------------------------
   // action decode
   // ----------------------------------------------------------
   always_comb begin
      res_forward_next = 1'b0;
      res_learn_next = 1'b0;
      res_drop_next = 1'b0;
      res_shutdown_next = 1'b0;
      if (!any_hit) begin
         res_drop_next = miss_drop_in;
         res_forward_next = !miss_drop_in;
         res_learn_next = !miss_drop_in;
      end else begin
         case (hit_action)
            IFC_ACT_PERMIT: begin
               res_forward_next = 1'b1;
               res_learn_next = 1'b1;
            end
            IFC_ACT_DENY: begin
               res_drop_next = 1'b1;
            end
            IFC_ACT_SHUTDOWN: begin
               // port shutdown itself is left disabled
               res_drop_next = 1'b1;
               res_shutdown_next = 1'b1;
            end
            default: begin
               res_drop_next = 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------
   // result register
   // ----------------------------------------------------------
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         res_valid_reg <= 1'b0;
         res_forward_reg <= 1'b0;
         res_learn_reg <= 1'b0;
         res_drop_reg <= 1'b0;
         res_shutdown_reg <= 1'b0;
         res_hit_reg <= 1'b0;
         res_idx_reg <= '0;
      end else begin
         res_valid_reg <= frm_valid_in;
         res_forward_reg <= frm_valid_in && res_forward_next;
         res_learn_reg <= frm_valid_in && res_learn_next;
         res_drop_reg <= frm_valid_in && res_drop_next;
         res_shutdown_reg <= frm_valid_in && res_shutdown_next;
         res_hit_reg <= frm_valid_in && any_hit;
         res_idx_reg <= hit_idx;
      end
   end

   // ----------------------------------------------------------
   // statistics
   // ----------------------------------------------------------
   // counters wrap silently; software reads differences
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         fwd_count_reg <= IFC_CNT_RST;
         drop_count_reg <= IFC_CNT_RST;
         shut_count_reg <= IFC_CNT_RST;
      end else begin
         if (res_valid_reg && res_forward_reg) begin
            fwd_count_reg <= fwd_count_reg + IFC_CNT_STEP;
         end
         if (res_valid_reg && res_drop_reg) begin
            drop_count_reg <= drop_count_reg + IFC_CNT_STEP;
         end
         if (res_valid_reg && res_shutdown_reg) begin
            shut_count_reg <= shut_count_reg + IFC_CNT_STEP;
         end
      end
   end

   // ----------------------------------------------------------
   // outputs
   // ----------------------------------------------------------
   assign cfg_rd_entry_out = rd_entry_reg;
   assign cfg_rd_conflict_out = rd_conflict_reg;
   assign cfg_rd_installed_out = rd_installed_reg;
   assign conflict_out = conflict_reg;
   assign installed_out = installed_reg;
   assign res_valid_out = res_valid_reg;
   assign res_forward_out = res_forward_reg;
   assign res_learn_out = res_learn_reg;
   assign res_drop_out = res_drop_reg;
   assign res_shutdown_out = res_shutdown_reg;
   assign res_hit_out = res_hit_reg;
   assign res_idx_out = res_idx_reg;
   assign fwd_count_out = fwd_count_reg;
   assign drop_count_out = drop_count_reg;
   assign shut_count_out = shut_count_reg;

endmodule
`default_nettype wire

/* common/ifc_pkg.sv */
// shared types and constants for the ipv4 frame filter classifier
package ifc_pkg;

   // ----------------------------------------------------------
   // sizes
   // ----------------------------------------------------------
   localparam int IFC_ENTRIES = 16;
   localparam int IFC_RANGE_UNITS = 4;
   localparam int IFC_ADDR_W = 32;
   localparam int IFC_PORT_W = 16;
   localparam int IFC_PROTO_W = 8;
   localparam int IFC_CNT_W = 32;
   localparam logic [IFC_CNT_W-1:0] IFC_CNT_RST = 32'h0000_0000;
   localparam logic [IFC_CNT_W-1:0] IFC_CNT_STEP = 32'h0000_0001;

   // ----------------------------------------------------------
   // encodings
   // ----------------------------------------------------------
   typedef enum logic [1:0] {
      IFC_ACT_PERMIT = 2'h0,
      IFC_ACT_DENY = 2'h1,
      IFC_ACT_SHUTDOWN = 2'h2
   } ifc_action_e;

   typedef enum logic [1:0] {
      IFC_PSEL_ANY = 2'h0,
      IFC_PSEL_SINGLE = 2'h1,
      IFC_PSEL_RANGE = 2'h2
   } ifc_psel_e;

   typedef enum logic [1:0] {
      IFC_FLAG_DONT_CARE = 2'h0,
      IFC_FLAG_SET = 2'h1,
      IFC_FLAG_UNSET = 2'h2
   } ifc_flag_e;

   // ----------------------------------------------------------
   // carriers
   // ----------------------------------------------------------
   typedef struct packed {
      logic [IFC_PROTO_W-1:0] proto;
      logic [IFC_ADDR_W-1:0] src_addr;
      logic [IFC_ADDR_W-1:0] dst_addr;
      logic [IFC_PORT_W-1:0] src_port;
      logic [IFC_PORT_W-1:0] dst_port;
      logic urg;
      logic ack;
      logic psh;
      logic rst;
   } ifc_frame_s;

   typedef struct packed {
      logic valid;
      ifc_action_e action;
      logic protocol_dont_care;
      logic [IFC_PROTO_W-1:0] proto;
      logic src_user;
      logic [IFC_ADDR_W-1:0] src_addr;
      logic [IFC_ADDR_W-1:0] source_address_mask;
      logic dst_user;
      logic [IFC_ADDR_W-1:0] dst_addr;
      logic [IFC_ADDR_W-1:0] destination_address_mask;
      ifc_psel_e sp_sel;
      logic [IFC_PORT_W-1:0] sp_lo;
      logic [IFC_PORT_W-1:0] sp_hi;
      ifc_psel_e dp_sel;
      logic [IFC_PORT_W-1:0] dp_lo;
      logic [IFC_PORT_W-1:0] dp_hi;
      ifc_flag_e urg;
      ifc_flag_e ack;
      ifc_flag_e psh;
      ifc_flag_e rst;
   } ifc_entry_s;

   localparam ifc_entry_s IFC_ENTRY_RST = '0;

endpackage

/* verilog/ifc_entry_match.sv */
// one filter_entry compared against one parsed frame header
`timescale 1ns/1ps
`default_nettype none
module ifc_entry_match
   import ifc_pkg::*;
(
   input wire ifc_entry_s entry_in,
   input wire ifc_frame_s frame_in,
   output logic hit_out
);

   // ----------------------------------------------------------
   // term helpers
   // ----------------------------------------------------------
   function automatic logic port_ok(input ifc_psel_e sel,
                                    input logic [IFC_PORT_W-1:0] p,
                                    input logic [IFC_PORT_W-1:0] lo,
                                    input logic [IFC_PORT_W-1:0] hi);
      case (sel)
         IFC_PSEL_ANY: port_ok = 1'b1;
         IFC_PSEL_SINGLE: port_ok = (p == lo);
         IFC_PSEL_RANGE: port_ok = (p >= lo) && (p <= hi);
         default: port_ok = 1'b0;
      endcase
   endfunction

   function automatic logic flag_ok(input ifc_flag_e t,
                                    input logic f);
      case (t)
         IFC_FLAG_DONT_CARE: flag_ok = 1'b1;
         IFC_FLAG_SET: flag_ok = f;
         IFC_FLAG_UNSET: flag_ok = !f;
         default: flag_ok = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------
   // terms
   // ----------------------------------------------------------
   wire logic proto_hit;
   wire logic src_hit;
   wire logic dst_hit;
   wire logic sp_hit;
   wire logic dp_hit;
   wire logic flags_hit;

   assign proto_hit = entry_in.protocol_dont_care ||
                      (frame_in.proto == entry_in.proto);
   // mask one means ignore that bit
   assign src_hit = !entry_in.src_user ||
      (((frame_in.src_addr ^ entry_in.src_addr) &
        ~entry_in.source_address_mask) == '0);
   assign dst_hit = !entry_in.dst_user ||
      (((frame_in.dst_addr ^ entry_in.dst_addr) &
        ~entry_in.destination_address_mask) == '0);
   assign sp_hit = port_ok(entry_in.sp_sel,
      frame_in.src_port, entry_in.sp_lo,
      entry_in.sp_hi);
   assign dp_hit = port_ok(entry_in.dp_sel,
      frame_in.dst_port, entry_in.dp_lo,
      entry_in.dp_hi);
   assign flags_hit = flag_ok(entry_in.urg, frame_in.urg) &&
                      flag_ok(entry_in.ack, frame_in.ack) &&
                      flag_ok(entry_in.psh, frame_in.psh) &&
                      flag_ok(entry_in.rst, frame_in.rst);

   assign hit_out = proto_hit && src_hit && dst_hit &&
                    sp_hit && dp_hit && flags_hit;

endmodule
`default_nettype wire

/* verilog/ifc_first_hit.sv */
// lowest-index hit finder over the entry hit vector
`timescale 1ns/1ps
`default_nettype none
module ifc_first_hit
   import ifc_pkg::*;
#(
   parameter int N = IFC_ENTRIES,
   parameter int IW = 4
)
(
   input wire logic [N-1:0] hits_in,
   output logic any_out,
   output logic [IW-1:0] idx_out
);

   // ----------------------------------------------------------
   // priority scan
   // ----------------------------------------------------------
   // scan from the top so the lowest sequence wins last
   always_comb begin
      any_out = 1'b0;
      idx_out = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (hits_in[i]) begin
            any_out = 1'b1;
            idx_out = IW'(i);
         end
      end
   end

endmodule
`default_nettype wire

/* sim/ifc_ingress_model.sv */
// ingress port model handing parsed frame headers to the classifier
`timescale 1ns/1ps
`default_nettype none
module ifc_ingress_model
   import ifc_pkg::*;
(
   input wire logic core_clk_in,
   output logic frm_valid_out,
   output ifc_frame_s frm_out
);
   initial begin
      frm_valid_out = 1'b0;
      frm_out = '0;
   end
   // stale header inverted, so no held value is trusted
   task automatic send(input ifc_frame_s f);
      @(posedge core_clk_in);
      #1;
      frm_valid_out = 1'b1;
      frm_out = f;
      @(posedge core_clk_in);
      #1;
      frm_valid_out = 1'b0;
      frm_out = ~f;
   endtask
endmodule
`default_nettype wire

/* sim/ifc_classifier_checker.sv */
// concurrent checks on the classifier top ports
`timescale 1ns/1ps
`default_nettype none
module ifc_classifier_checker
   import ifc_pkg::*;
#(
   parameter int N = IFC_ENTRIES,
   parameter int IW = 4
)
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic cfg_wr_in,
   input wire logic [IW-1:0] cfg_idx_in,
   input wire ifc_entry_s cfg_entry_in,
   input wire logic cfg_clear_in,
   input wire logic [N-1:0] conflict_out,
   input wire logic [N-1:0] installed_out,
   input wire logic miss_drop_in,
   input wire logic frm_valid_in,
   input wire logic res_valid_out,
   input wire logic res_forward_out,
   input wire logic res_learn_out,
   input wire logic res_drop_out,
   input wire logic res_shutdown_out,
   input wire logic res_hit_out,
   input wire logic [IW-1:0] res_idx_out,
   input wire logic [IFC_CNT_W-1:0] fwd_count_out,
   input wire logic [IFC_CNT_W-1:0] drop_count_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   // table as it stood when the frame was taken
   logic [N-1:0] inst_q;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         inst_q <= '0;
      end else begin
         inst_q <= installed_out;
      end
   end
   property p_answer; frm_valid_in |=> res_valid_out; endproperty
   a_answer: assert property (p_answer) else $error("no result");
   property p_quiet; !frm_valid_in |=> !res_valid_out; endproperty
   a_quiet: assert property (p_quiet) else $error("stray result");
   property p_permit;
      res_forward_out |-> res_learn_out && res_valid_out && !res_drop_out;
   endproperty
   a_permit: assert property (p_permit) else $error("bad permit");
   property p_deny;
      res_drop_out |-> !res_forward_out && !res_learn_out && res_valid_out;
   endproperty
   a_deny: assert property (p_deny) else $error("bad drop");
   property p_shut; res_shutdown_out |-> res_drop_out; endproperty
   a_shut: assert property (p_shut) else $error("bad shutdown");
   property p_miss;
      res_valid_out && !res_hit_out |-> res_drop_out == $past(miss_drop_in);
   endproperty
   a_miss: assert property (p_miss) else $error("bad miss");
   property p_hit; res_hit_out |-> res_valid_out && inst_q[res_idx_out];
   endproperty
   a_hit: assert property (p_hit) else $error("hit on idle entry");
   property p_excl; (conflict_out & installed_out) == '0; endproperty
   a_excl: assert property (p_excl) else $error("conflict used");
   property p_void;
      cfg_wr_in && !cfg_clear_in && !cfg_entry_in.valid |=>
         !installed_out[$past(cfg_idx_in)] && !conflict_out[$past(cfg_idx_in)];
   endproperty
   a_void: assert property (p_void) else $error("void entry kept");
   property p_clear; cfg_clear_in |=> installed_out == '0; endproperty
   a_clear: assert property (p_clear) else $error("clear failed");
   property p_fcnt;
      res_forward_out |=> fwd_count_out == $past(fwd_count_out) + IFC_CNT_STEP;
   endproperty
   a_fcnt: assert property (p_fcnt) else $error("fwd count");
   property p_dcnt;
      res_drop_out |=> drop_count_out == $past(drop_count_out) + IFC_CNT_STEP;
   endproperty
   a_dcnt: assert property (p_dcnt) else $error("drop count");
   c_permit: cover property (res_forward_out && res_hit_out);
   c_deny: cover property (res_drop_out && res_hit_out && !res_shutdown_out);
   c_shut: cover property (res_shutdown_out);
   c_conflict: cover property (|conflict_out);
endmodule
bind ifc_classifier ifc_classifier_checker #(.N(N), .IW(IW)) chk_u (.*);
`default_nettype wire

/* sim/test_ifc_classifier.sv */
// self-checking bench for the ipv4 frame filter classifier
`timescale 1ns/1ps
`default_nettype none
module test_ifc_classifier;
   import ifc_pkg::*;
   logic core_clk_in, rst_in, cfg_wr_in, cfg_clear_in, miss_drop_in;
   logic frm_valid_in, cfg_rd_conflict_out, cfg_rd_installed_out;
   logic [3:0] cfg_idx_in, cfg_rd_idx_in, res_idx_out;
   ifc_entry_s cfg_entry_in, cfg_rd_entry_out, e;
   ifc_frame_s frm_in, f;
   ifc_flag_e sf;
   logic [15:0] conflict_out, installed_out;
   logic res_valid_out, res_forward_out, res_learn_out, res_drop_out;
   logic res_shutdown_out, res_hit_out;
   logic [31:0] fwd_count_out, drop_count_out, shut_count_out;
   int miscompares = 0, tests_run = 0, n_fwd = 0, n_drop = 0, n_shut = 0;
   ifc_classifier dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in),
      .cfg_wr_in(cfg_wr_in), .cfg_idx_in(cfg_idx_in),
      .cfg_entry_in(cfg_entry_in), .cfg_clear_in(cfg_clear_in),
      .cfg_rd_idx_in(cfg_rd_idx_in), .cfg_rd_entry_out(cfg_rd_entry_out),
      .cfg_rd_conflict_out(cfg_rd_conflict_out),
      .cfg_rd_installed_out(cfg_rd_installed_out),
      .conflict_out(conflict_out), .installed_out(installed_out),
      .miss_drop_in(miss_drop_in), .frm_valid_in(frm_valid_in),
      .frm_in(frm_in), .res_valid_out(res_valid_out),
      .res_forward_out(res_forward_out), .res_learn_out(res_learn_out),
      .res_drop_out(res_drop_out), .res_shutdown_out(res_shutdown_out),
      .res_hit_out(res_hit_out), .res_idx_out(res_idx_out),
      .fwd_count_out(fwd_count_out), .drop_count_out(drop_count_out),
      .shut_count_out(shut_count_out));
   ifc_ingress_model ing_u (.core_clk_in(core_clk_in),
      .frm_valid_out(frm_valid_in), .frm_out(frm_in));
   // ----------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------
   task automatic conclude;
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp(input string n, input logic [255:0] x,
         input logic [255:0] g);
      tests_run++;
      if (g !== x) begin
         miscompares++;
         $display("[FAIL] %s expected %0h seen %0h", n, x, g);
      end
   endtask
   task automatic tick;
      @(posedge core_clk_in);
      #1;
   endtask
   task automatic wr_entry(input logic [3:0] i, input ifc_entry_s v);
      tick();
      cfg_wr_in = 1'b1;
      cfg_idx_in = i;
      cfg_entry_in = v;
      tick();
      cfg_wr_in = 1'b0;
      cfg_entry_in = ~v;
   endtask
   function automatic ifc_frame_s mk(logic [7:0] p, logic [31:0] s, d,
         logic [15:0] sp, dp, logic [3:0] fl);
      return {p, s, d, sp, dp, fl};
   endfunction
   // ei < 0 means no entry hit; ea 0 forward, 1 drop, 2 shutdown
   task automatic chk(input ifc_frame_s f, input int ei, input int ea);
      ing_u.send(f);
      cmp("res_valid", 1, res_valid_out);
      cmp("res_hit", ei >= 0, res_hit_out);
      if (ei >= 0) begin
         cmp("res_idx", ei[3:0], res_idx_out);
      end
      cmp("res_forward", ea == 0, res_forward_out);
      cmp("res_learn", ea == 0, res_learn_out);
      cmp("res_drop", ea != 0, res_drop_out);
      cmp("res_shutdown", ea == 2, res_shutdown_out);
      n_fwd += (ea == 0);
      n_drop += (ea != 0);
      n_shut += (ea == 2);
   endtask
   // ----------------------------------------------------------
   // sequence
   // ----------------------------------------------------------
   initial begin
      core_clk_in = 1'b0;
      forever #2.5 core_clk_in = ~core_clk_in;
   end
   initial begin
      #200000;
      miscompares++;
      conclude();
   end
   initial begin
      rst_in = 1'b1;
      cfg_wr_in = 1'b0;
      cfg_clear_in = 1'b0;
      miss_drop_in = 1'b0;
      cfg_idx_in = 4'h0;
      cfg_rd_idx_in = 4'h0;
      cfg_entry_in = '0;
      repeat (5) @(posedge core_clk_in);
      #1;
      rst_in = 1'b0;
      cmp("installed", 0, installed_out);
      cmp("fwd_count", 0, fwd_count_out);
      chk('0, -1, 0);
      miss_drop_in = 1'b1;
      chk('0, -1, 1);
      // fields: valid action anyproto proto src mask dst mask ports flags
      e = {1'b1, IFC_ACT_DENY, 1'b0, 8'h06, 1'b1, 32'h0A00_0000, 32'h0000_00FF,
         1'b0, 64'h0, IFC_PSEL_ANY, 32'h0, IFC_PSEL_ANY, 32'h0, 8'h00};
      wr_entry(4'h0, e);
      tick();
      cmp("rd_entry", e, cfg_rd_entry_out);
      cmp("rd_installed", 1, cfg_rd_installed_out);
      wr_entry(4'h1, {1'b1, IFC_ACT_PERMIT, 1'b1, 8'h00, 1'b0, 64'h0, 1'b1,
         32'hC0A8_0101, 32'h0, IFC_PSEL_SINGLE, 32'hFFFF_0000, IFC_PSEL_RANGE,
         32'h0050_005A, IFC_FLAG_SET, IFC_FLAG_UNSET, 4'h0});
      e = IFC_ENTRY_RST;
      e.valid = 1'b1;
      e.action = IFC_ACT_SHUTDOWN;
      e.protocol_dont_care = 1'b1;
      wr_entry(4'h2, e);
      f = mk(8'h06, 32'h0A00_0137, 32'h0, 16'h0, 16'h0, 4'h0);
      chk(f, 2, 2);
      f.src_addr = 32'h0A00_0037;
      f.proto = 8'h11;
      chk(f, 2, 2);
      f = mk(8'h06, 32'h0A00_0037, 32'hC0A8_0101, 16'hFFFF, 16'h50, 4'h8);
      chk(f, 0, 1);
      f.proto = 8'h11;
      chk(f, 1, 0);
      f.dst_port = 16'h5A;
      f.psh = 1'b1;
      f.rst = 1'b1;
      chk(f, 1, 0);
      f.dst_port = 16'h5B;
      chk(f, 2, 2);
      f.dst_port = 16'h50;
      f.src_port = 16'hFFFE;
      chk(f, 2, 2);
      f.src_port = 16'hFFFF;
      f.ack = 1'b1;
      chk(f, 2, 2);
      f.ack = 1'b0;
      f.dst_addr = 32'hC0A8_0100;
      chk(f, 2, 2);
      for (int i = 0; i < 4; i++) begin
         for (int m = 0; m < 2; m++) begin
            sf = m ? IFC_FLAG_UNSET : IFC_FLAG_SET;
            e = {1'b1, IFC_ACT_PERMIT, 1'b1, 73'h0, 1'b1, 32'hC0A8_0202, 32'h0,
               IFC_PSEL_ANY, 32'h0, IFC_PSEL_ANY, 32'h0, 8'h00};
            case (i)
               0: e.urg = sf;
               1: e.ack = sf;
               2: e.psh = sf;
               default: e.rst = sf;
            endcase
            wr_entry(4'h0, e);
            f = mk(8'h06, 32'h0, 32'hC0A8_0202, 16'h0, 16'h0, 4'h8 >> i);
            chk(f, m * 2, m * 2);
            f[3:0] = 4'h0;
            chk(f, 2 - m * 2, 2 - m * 2);
         end
      end
      e = {1'b1, IFC_ACT_PERMIT, 1'b1, 73'h0, 1'b1, 32'hC0A8_0303, 32'h0,
         IFC_PSEL_RANGE, 32'h03E8_07D0, IFC_PSEL_SINGLE, 32'h1234_0000, 8'h00};
      wr_entry(4'h0, e);
      f = mk(8'h06, 32'h0, 32'hC0A8_0303, 16'h03E8, 16'h1234, 4'h0);
      chk(f, 0, 0);
      f.src_port = 16'h07D1;
      chk(f, 2, 2);
      f.src_port = 16'h07D0;
      f.dst_port = 16'h1235;
      chk(f, 2, 2);
      // two range units already taken, so one double-range entry fits
      e.dp_sel = IFC_PSEL_RANGE;
      e.dp_hi = 16'hFFFF;
      wr_entry(4'h3, e);
      cmp("installed3", 1, installed_out[3]);
      wr_entry(4'h4, e);
      cmp("conflict4", 1, conflict_out[4]);
      cmp("installed4", 0, installed_out[4]);
      cfg_rd_idx_in = 4'h4;
      tick();
      cmp("rd_conflict", 1, cfg_rd_conflict_out);
      cmp("rd_entry4", e, cfg_rd_entry_out);
      wr_entry(4'h5, IFC_ENTRY_RST);
      cmp("installed5", 0, installed_out[5]);
      tick();
      cfg_clear_in = 1'b1;
      tick();
      cfg_clear_in = 1'b0;
      cmp("cleared", 0, {conflict_out, installed_out});
      chk('0, -1, 1);
      tick();
      cmp("fwd_count", n_fwd, fwd_count_out);
      cmp("drop_count", n_drop, drop_count_out);
      cmp("shut_count", n_shut, shut_count_out);
      conclude();
   end
endmodule
`default_nettype wire
